// [logic/rsw_debounce.sv]
`timescale 1ns/1ns
module rsw_debounce
    import rsw_pkg::*;
#(
    parameter int unsigned CYCLES = DEB_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_sync,
    output logic      o_level
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          lvl_ff;
    wire           differs = (i_sync != lvl_ff);
    wire           done    = (cnt_ff == CW'(CYCLES - 1));

    // Level must hold steady CYCLES clocks; 100 ns glitches die here
    assign nxt_cnt = differs ? (done ? '0 : cnt_ff + CW'(1)) : '0;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= '0;
            lvl_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            if (differs && done) begin
                lvl_ff <= i_sync;
            end
        end
    end

    assign o_level = lvl_ff;
endmodule

// [logic/rsw_pkg.sv]
package rsw_pkg;

    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 20;

    // Times as specified, in their own units
    localparam int unsigned HOLD_TIME_MS     = 140;
    localparam int unsigned WD_PERIOD_MS     = 1120;
    localparam int unsigned BTN_DELAY_NS     = 5000;
    localparam int unsigned GLITCH_NS        = 100;
    localparam int unsigned TICK_NS          = 1000;

    // Time base tick: 1 us
    localparam int unsigned TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
    // Hold and watchdog intervals in ticks; least times round up
    localparam int unsigned HOLD_TICKS       = HOLD_TIME_MS * 1000;
    localparam int unsigned WD_TICKS         = WD_PERIOD_MS * 1000;
    // Button filter: longer than a glitch, well inside the press delay
    localparam int unsigned DEB_CYCLES_MIN   = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned DEB_CYCLES       = (BTN_DELAY_NS / CLK_PERIOD_NS) / 4;
    localparam int unsigned WD_LOW_NUM       = 7;
    localparam int unsigned WD_FRAC_DEN      = 8;

    typedef struct packed {
        logic supply_low;
        logic button;
        logic watchdog;
    } rsw_cause_t;

    typedef struct packed {
        logic o;
        logic oe_n;
    } rsw_pull_t;

endpackage

// [logic/rsw_top.sv]
`timescale 1ns/1ns
module rsw_top
    import rsw_pkg::*;
#(
    parameter int unsigned TICK_CYC  = TICK_CYCLES,
    parameter int unsigned HOLD_TK   = HOLD_TICKS,
    parameter int unsigned WD_TK     = WD_TICKS,
    parameter int unsigned DEB_CYC   = DEB_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_supply_low,
    input  wire logic i_pushbutton_reset_n,
    input  wire logic i_watchdog_strobe_in,
    output logic      o_watchdog_strobe_out,
    output logic      o_watchdog_strobe_oe_n,
    output logic      o_reset_n,
    output logic      o_reset
);
    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    localparam int unsigned HW = $clog2(HOLD_TK + 1);
    localparam int unsigned WW = $clog2(WD_TK + 1);
    localparam logic [WW-1:0] WD_LOW_TK = WW'(WD_TK / WD_FRAC_DEN * WD_LOW_NUM);

    typedef enum logic [1:0] {RSW_ASSERT, RSW_HOLD, RSW_RUN} rsw_state_t;

    // Pin synchronisers
    logic [1:0] sup_sync_ff;
    logic [1:0] btn_sync_ff;
    logic [1:0] wdi_sync_ff;
    logic       wdi_prev_ff;
    logic       btn_level;

    // Time base
    logic [TW-1:0] tick_cnt_ff;
    logic          tick_ff;

    rsw_state_t    state_ff;
    rsw_state_t    nxt_state;
    logic [HW-1:0] hold_cnt_ff;
    logic [HW-1:0] nxt_hold_cnt;
    logic [WW-1:0] wd_cnt_ff;
    logic [WW-1:0] nxt_wd_cnt;
    logic          wd_bite_ff;
    logic          float_ff;
    logic          rst_ff;
    logic          rst_n_ff;
    rsw_pull_t     pull_ff;
    rsw_cause_t    cause;

    rsw_debounce #(
        .CYCLES (DEB_CYC)
    ) u_debounce (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_sync  (btn_sync_ff[1]),
        .o_level (btn_level)
    );

    wire sup_low  = sup_sync_ff[1];
    wire watchdog_strobe_in      = wdi_sync_ff[1];
    wire wdi_edge = (watchdog_strobe_in != wdi_prev_ff);
    // Edges we caused ourselves by pulling do not count as a driver
    wire pulling  = !pull_ff.oe_n;
    wire own_edge = pulling && (watchdog_strobe_in == pull_ff.o);
    wire ext_edge = wdi_edge && !own_edge;
    wire wd_end   = (wd_cnt_ff == WW'(WD_TK - 1));
    wire hold_end = (hold_cnt_ff == HW'(HOLD_TK - 1));

    assign cause = '{
        supply_low: sup_low,
        button:     !btn_level,
        watchdog:   wd_bite_ff
    };
    wire   any_cause        = |cause;

    always_comb begin
        nxt_state    = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        case (state_ff)
            RSW_ASSERT: begin
                nxt_hold_cnt = '0;
                if (!any_cause) begin
                    nxt_state = RSW_HOLD;
                end
            end
            RSW_HOLD: begin
                if (any_cause) begin
                    nxt_state = RSW_ASSERT;
                end else if (tick_ff) begin
                    if (hold_end) begin
                        nxt_state = RSW_RUN;
                    end else begin
                        nxt_hold_cnt = hold_cnt_ff + HW'(1);
                    end
                end
            end
            RSW_RUN: begin
                if (any_cause) begin
                    nxt_state = RSW_ASSERT;
                end
            end
            default: nxt_state = RSW_ASSERT;
        endcase
    end

    // Watchdog runs only while reset is released
    always_comb begin
        nxt_wd_cnt = wd_cnt_ff;
        if (state_ff != RSW_RUN) begin
            nxt_wd_cnt = '0;
        end else if (ext_edge) begin
            nxt_wd_cnt = '0;
        end else if (tick_ff) begin
            nxt_wd_cnt = wd_end ? '0 : wd_cnt_ff + WW'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sup_sync_ff <= 2'h3;
            btn_sync_ff <= 2'h3;
            wdi_sync_ff <= 2'h0;
            wdi_prev_ff <= 1'b0;
        end else begin
            sup_sync_ff <= {sup_sync_ff[0], i_supply_low};
            btn_sync_ff <= {btn_sync_ff[0], i_pushbutton_reset_n};
            wdi_sync_ff <= {wdi_sync_ff[0], i_watchdog_strobe_in};
            wdi_prev_ff <= watchdog_strobe_in;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else begin
            tick_ff     <= (tick_cnt_ff == TW'(TICK_CYC - 1));
            tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + TW'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff    <= RSW_ASSERT;
            hold_cnt_ff <= '0;
            wd_cnt_ff   <= '0;
        end else begin
            state_ff    <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
            wd_cnt_ff   <= nxt_wd_cnt;
        end
    end

    // Floating detect: a pulled level read back means nobody drives the pin
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            float_ff <= 1'b1;
        end else if (ext_edge || (pulling && watchdog_strobe_in != pull_ff.o && !wdi_edge)) begin
            float_ff <= 1'b0;
        end else if (pulling && own_edge && wdi_edge) begin
            float_ff <= 1'b1;
        end
    end

    // Bite only when driven; an open pin is self-serviced
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wd_bite_ff <= 1'b0;
        end else if (state_ff == RSW_ASSERT && !sup_low && btn_level) begin
            wd_bite_ff <= 1'b0;
        end else if (state_ff == RSW_RUN && tick_ff && wd_end && !ext_edge && !float_ff) begin
            wd_bite_ff <= 1'b1;
        end
    end

    // Weak pull is offered the clock after each RSW_RUN clock (oe_n high otherwise); a real driver simply overrides it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pull_ff <= '{o: 1'b0, oe_n: 1'b1};
        end else begin
            pull_ff.oe_n <= (state_ff != RSW_RUN);
            pull_ff.o    <= (wd_cnt_ff >= WD_LOW_TK);
        end
    end

    // Two flops from one next state: both pins registered, never apart
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_ff   <= 1'b1;
            rst_n_ff <= 1'b0;
        end else begin
            rst_ff   <= (nxt_state != RSW_RUN);
            rst_n_ff <= (nxt_state == RSW_RUN);
        end
    end

    assign o_reset_n              = rst_n_ff;
    assign o_reset                = rst_ff;
    assign o_watchdog_strobe_out  = pull_ff.o;
    assign o_watchdog_strobe_oe_n = pull_ff.oe_n;
endmodule

// [testbench/rsw_checker.sv]
`timescale 1ns/1ns
module rsw_checker
    import rsw_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned HOLD_TK  = HOLD_TICKS,
    parameter int unsigned WD_TK    = WD_TICKS,
    parameter int unsigned DEB_CYC  = DEB_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_supply_low,
    input wire logic i_pushbutton_reset_n,
    input wire logic i_watchdog_strobe_in,
    input wire logic o_watchdog_strobe_out,
    input wire logic o_watchdog_strobe_oe_n,
    input wire logic o_reset_n,
    input wire logic o_reset
);
    int q_ff;
    int w_ff;
    int b_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Raw inputs lead the synchronisers, so these counts err on the safe side
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_ff <= 0;
            w_ff <= 0;
            b_ff <= 0;
        end else begin
            q_ff <= (o_reset && !i_supply_low && i_pushbutton_reset_n) ? q_ff + 1 : 0;
            w_ff <= (o_reset || $changed(i_watchdog_strobe_in)) ? 0 : w_ff + 1;
            b_ff <= i_pushbutton_reset_n ? 0 : b_ff + 1;
        end
    end
    sequence s_sup;
        i_supply_low [*4];
    endsequence
    sequence s_rst_on;
        o_reset [*3];
    endsequence
    property p_cpl;
        o_reset_n != o_reset;
    endproperty
    property p_sup;
        i_supply_low |-> ##[1:4] o_reset;
    endproperty
    property p_sup_hold;
        s_sup |-> o_reset;
    endproperty
    property p_btn;
        b_ff == DEB_CYC + 5 |-> o_reset;
    endproperty
    property p_hold;
        $fell(o_reset) |-> $past(q_ff) >= (HOLD_TK - 1) * TICK_CYC;
    endproperty
    property p_wd_max;
        w_ff <= (WD_TK + 1) * TICK_CYC + 6;
    endproperty
    property p_wd_min;
        $rose(o_reset) && !i_supply_low && i_pushbutton_reset_n
            |-> $past(w_ff) >= (WD_TK - 1) * TICK_CYC;
    endproperty
    property p_oe;
        s_rst_on |-> o_watchdog_strobe_oe_n;
    endproperty
    a_cpl: assert property (p_cpl) else $error("reset outputs not complementary");
    a_sup: assert property (p_sup) else $error("supply low gave no reset");
    a_sup_hold: assert property (p_sup_hold) else $error("reset dropped in low supply");
    a_btn: assert property (p_btn) else $error("button press gave no reset");
    a_hold: assert property (p_hold) else $error("reset hold too short");
    a_wd_max: assert property (p_wd_max) else $error("watchdog did not bite");
    a_wd_min: assert property (p_wd_min) else $error("watchdog bit early");
    a_oe: assert property (p_oe) else $error("pull active in reset");
endmodule
bind rsw_top rsw_checker #(.TICK_CYC(TICK_CYC), .HOLD_TK(HOLD_TK), .WD_TK(WD_TK),
    .DEB_CYC(DEB_CYC)) chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_low(i_supply_low),
    .i_pushbutton_reset_n(i_pushbutton_reset_n), .i_watchdog_strobe_in(i_watchdog_strobe_in),
    .o_watchdog_strobe_out(o_watchdog_strobe_out),
    .o_watchdog_strobe_oe_n(o_watchdog_strobe_oe_n), .o_reset_n(o_reset_n), .o_reset(o_reset));

// [testbench/rsw_cpu.sv]
`timescale 1ns/1ns
module rsw_cpu (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_pull_o,
    input  wire logic       i_pull_oe_n,
    output logic            o_wire
);
    int   cnt_ff = 0;
    logic drv_ff = 1'b0;
    logic flt_ff = 1'b0;
    always @(posedge i_clk) begin
        cnt_ff <= (i_reset || cnt_ff == 59) ? 0 : cnt_ff + 1;
        drv_ff <= (cnt_ff >= 57);
        flt_ff <= !o_wire;
    end
    // Open pin with no pull toggles, so no stale level can pass for a drive
    assign o_wire = (i_mode == 2'h0) ? drv_ff : (i_mode == 2'h1) ? 1'b0 :
                    (!i_pull_oe_n ? i_pull_o : flt_ff);
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); end end
module testbench;
    localparam int TC = 2;
    localparam int HK = 20;
    localparam int WK = 80;
    localparam int DB = 8;
    localparam int HC = HK * TC;
    localparam int WC = WK * TC;
    logic       i_clk;
    logic       i_rst_n;
    logic       i_supply_low;
    logic       i_pushbutton_reset_n;
    logic [1:0] mode;
    logic       pin;
    logic       pull_o;
    logic       pull_oe_n;
    logic       o_reset;
    logic       hit;
    int         fails;
    int         cmp_count;
    int         n;
    int         ph;
    rsw_top #(.TICK_CYC(TC), .HOLD_TK(HK), .WD_TK(WK), .DEB_CYC(DB)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_low(i_supply_low),
        .i_pushbutton_reset_n(i_pushbutton_reset_n), .i_watchdog_strobe_in(pin),
        .o_watchdog_strobe_out(pull_o), .o_watchdog_strobe_oe_n(pull_oe_n),
        .o_reset_n(), .o_reset(o_reset));
    rsw_cpu cpu_u (.i_clk(i_clk), .i_reset(o_reset), .i_mode(mode), .i_pull_o(pull_o),
        .i_pull_oe_n(pull_oe_n), .o_wire(pin));
    task automatic wait_lvl(logic v, int max);
        n = 0;
        while (o_reset !== v && n < max) begin
            @(negedge i_clk);
            n++;
        end
    endtask
    task automatic watch(int c);
        hit = 1'b0;
        ph = 0;
        repeat (c) begin
            @(negedge i_clk);
            hit = hit | o_reset;
            ph += (!pull_oe_n && pull_o);
        end
    endtask
    // Hold is counted in whole ticks, so allow one tick below and one tick plus 8 clocks above
    // Lag: cycles the cause needs to clear inside, e.g. the button filter
    task automatic hold_chk(string s, int lag);
        wait_lvl(1'b0, 5000);
        `CHK(s, 1'b1, (n >= HC - TC + lag && n <= HC + TC + 8 + lag))
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        $display("ERROR run exp done got hang");
        results();
    end
    initial begin
        i_rst_n = 1'b0;
        i_supply_low = 1'b0;
        i_pushbutton_reset_n = 1'b1;
        mode = 2'h0;
        fails = 0;
        cmp_count = 0;
        void'($urandom(32'hadb77989));
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        hold_chk("pwr_hold", 0);
        $display("test power_up done");
        @(posedge i_clk) i_supply_low <= 1'b1;
        wait_lvl(1'b1, 5);
        `CHK("sup_asrt", 1'b1, o_reset)
        repeat ($urandom_range(40, 10)) @(posedge i_clk);
        i_supply_low <= 1'b0;
        hold_chk("sup_hold", 0);
        @(posedge i_clk) i_supply_low <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_supply_low <= 1'b0;
        repeat ($urandom_range(30, 10)) @(posedge i_clk);
        i_supply_low <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_supply_low <= 1'b0;
        hold_chk("sup_rehold", 0);
        $display("test supply done");
        @(posedge i_clk) i_pushbutton_reset_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_pushbutton_reset_n <= 1'b1;
        watch(DB + 10);
        `CHK("glitch", 1'b0, hit)
        @(posedge i_clk) i_pushbutton_reset_n <= 1'b0;
        wait_lvl(1'b1, DB + 6);
        `CHK("btn_asrt", 1'b1, o_reset)
        repeat ($urandom_range(60, 20)) @(posedge i_clk);
        i_pushbutton_reset_n <= 1'b1;
        hold_chk("btn_hold", DB);
        $display("test button done");
        watch(3 * WC);
        `CHK("strobed", 1'b0, hit)
        @(posedge i_clk) mode <= 2'h1;
        wait_lvl(1'b1, WC + TC + 10);
        `CHK("bite", 1'b1, o_reset)
        hold_chk("bite_hold", 0);
        wait_lvl(1'b1, WC + TC + 12);
        `CHK("rebite", 1'b1, (n >= WC - TC - 4 && o_reset === 1'b1))
        @(posedge i_clk) mode <= 2'h2;
        hold_chk("open_hold", 0);
        watch(4 * WC);
        `CHK("open_quiet", 1'b0, hit)
        `CHK("pull_high", 1'b1, (ph >= 3 * WC / 8 && ph <= 5 * WC / 8))
        $display("test watchdog done");
        results();
    end
endmodule
